// ===== bench/spi_far_model.sv
// Far side: pulled-up select wires and a replying subordinate.
`timescale 1ns/10ps
module spi_far_model (
  input wire logic sclk, mosi,
  input wire logic [3:0] lvl, oeN,
  output logic miso,
  output logic [3:0] seen
);
  assign seen = lvl | oeN;
  initial miso = 1'b0;
  always @(negedge sclk) miso <= ~mosi;
endmodule

// ===== bench/spi_route_checker.sv
// Port checks for the routed select pass-through.
`timescale 1ns/10ps
module spi_route_checker (
  input wire logic clk, reset_n, host_clk_in, far_clk_out,
  input wire logic host_to_far_data_in, host_to_far_data_out,
  input wire logic far_to_host_data_in, far_to_host_data_out,
  input wire logic host_select_n, routed_select_0, route_addr_lo, route_addr_hi,
  input wire logic routed_select_0_oe_n, routed_select_1_oe_n,
  input wire logic routed_select_2_oe_n, routed_select_3_oe_n,
  input wire logic routeChange
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [3:0] oeN = {routed_select_3_oe_n, routed_select_2_oe_n,
    routed_select_1_oe_n, routed_select_0_oe_n};
  wire [1:0] addr = {route_addr_hi, route_addr_lo};
  wire [3:0] want = ~(4'h1 << addr);
  sequence addr_move; $changed(addr); endsequence
  sequence route_set; oeN == want; endsequence
  a_clk_copy: assert property (far_clk_out == host_clk_in)
    else $error("clk");
  a_mosi_copy: assert property (host_to_far_data_out == host_to_far_data_in)
    else $error("mosi");
  a_miso_copy: assert property (far_to_host_data_out == far_to_host_data_in)
    else $error("miso");
  a_one_enable: assert property ($onehot(~oeN))
    else $error("enables");
  a_level_copy: assert property (!routed_select_0_oe_n |-> routed_select_0 == host_select_n)
    else $error("level");
  a_route_delay: assert property (addr_move |-> ##[1:104] route_set)
    else $error("late");
  a_no_early: assert property (addr_move |=> $stable(oeN))
    else $error("early");
  a_route_match: assert property ($changed(oeN) |-> route_set)
    else $error("index");
  a_change_flag: assert property (routeChange |=> ($changed(oeN) && route_set))
    else $error("flag");
endmodule
bind spi_select_demux_passthrough spi_route_checker chk (.*);

// ===== bench/test_spi_select_demux_passthrough.sv
// Self-checking bench for the routed select pass-through.
`timescale 1ns/10ps
module test_spi_select_demux_passthrough;
  logic clk = 0, reset_n = 0, sclk = 0, mosi = 0, ssN = 1, aLo = 0, aHi = 0;
  logic miso, mOut, cOut, dOut, rc;
  logic [3:0] lvl, oeN, seen;
  logic [31:0] seed = 32'hC;
  int n_fail = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  spi_select_demux_passthrough #(.SAMPLE_DIV(4)) uut (.clk(clk), .reset_n(reset_n),
    .host_clk_in(sclk), .host_to_far_data_in(mosi), .far_to_host_data_out(mOut),
    .host_select_n(ssN), .route_addr_lo(aLo), .route_addr_hi(aHi), .far_clk_out(cOut),
    .host_to_far_data_out(dOut), .far_to_host_data_in(miso), .routeChange(rc),
    .routed_select_0(lvl[0]), .routed_select_0_oe_n(oeN[0]),
    .routed_select_1(lvl[1]), .routed_select_1_oe_n(oeN[1]),
    .routed_select_2(lvl[2]), .routed_select_2_oe_n(oeN[2]),
    .routed_select_3(lvl[3]), .routed_select_3_oe_n(oeN[3]));
  spi_far_model far (.sclk(cOut), .mosi(dOut), .lvl(lvl), .oeN(oeN), .miso(miso), .seen(seen));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [3:0] want(input logic [1:0] a, input logic s);
    want = 4'hF;
    want[a] = s;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic frame(input logic [1:0] a);
    ssN = 1'b0;
    repeat (16) begin
      seed = xs(seed);
      if (!sclk) mosi = seed[0];
      repeat (4) @(negedge clk);
      sclk = ~sclk;
      #1 chk("wire", {1'h0, sclk, mosi, miso, want(a, 0)}, {1'h0, cOut, dOut, mOut, seen});
    end
    ssN = 1'b1;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    for (int t = 0; t < 8; t++) begin
      seed = xs(seed);
      {aHi, aLo} = (t < 4) ? t[1:0] : seed[1:0];
      repeat (20) @(negedge clk);
      chk("idle", {3'h0, miso, want({aHi, aLo}, 1)}, {3'h0, mOut, seen});
      frame({aHi, aLo});
      repeat (100) @(negedge clk);
      $display("route %0d done", t);
    end
    print_verdict;
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule

// ===== logic/route_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module route_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData = mem_ff[rdPtr_ff];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doWrite) wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      if (doRead) rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end

  always_ff @(posedge clk) begin
    if (doWrite) mem_ff[wrPtr_ff] <= inData;
  end
endmodule

// ===== logic/spi_route_pkg.sv
// Shared constants for the select-routing pass-through.
package spi_route_pkg;
  localparam int CLK_HZ = 40000000;
  localparam real ROUTE_DELAY_MAX_US = 2.6;
  localparam real ROUTE_HOLD_MIN_US = 4.0;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ROUTE_DELAY_MAX_CYCLES = int'($floor(ROUTE_DELAY_MAX_US * 1000.0 / 25.0));
  localparam int ROUTE_HOLD_MIN_CYCLES = int'($ceil(ROUTE_HOLD_MIN_US * 1000.0 / 25.0));
  localparam logic [1:0] ROUTE_RESET = 2'h0;
  localparam int FIFO_WIDTH = 2;
  localparam int FIFO_DEPTH = 16;
endpackage

// ===== logic/spi_select_demux_passthrough.sv
// SPI pass-through with a four-way routed select demultiplexer.
`timescale 1ns/10ps
module spi_select_demux_passthrough
  import spi_route_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host side
  input wire logic host_clk_in,
  input wire logic host_to_far_data_in,
  output logic far_to_host_data_out,
  input wire logic host_select_n,
  input wire logic route_addr_lo,
  input wire logic route_addr_hi,
  // Far side
  output logic far_clk_out,
  output logic host_to_far_data_out,
  input wire logic far_to_host_data_in,
  // Routed selects, enable low while driven
  output logic routed_select_0,
  output logic routed_select_0_oe_n,
  output logic routed_select_1,
  output logic routed_select_1_oe_n,
  output logic routed_select_2,
  output logic routed_select_2_oe_n,
  output logic routed_select_3,
  output logic routed_select_3_oe_n,
  // Route change observation
  output logic routeChange
);
  // Fast paths are combinational so no clock latency is added to SPI.
  assign far_clk_out = host_clk_in;
  assign host_to_far_data_out = host_to_far_data_in;
  assign far_to_host_data_out = far_to_host_data_in;

  // Address bits are synchronised and sampled by a free-running tick.
  logic [1:0] addrMeta_ff;
  logic [1:0] addrSync_ff;
  logic [1:0] addrSample_ff;
  logic [1:0] route_ff;
  logic [15:0] tickCnt_ff;
  logic [1:0] fifoData;
  logic fifoValid;
  logic fifoReady;
  wire tick = (tickCnt_ff == 16'(SAMPLE_DIV - 1));
  wire [1:0] rawAddr = {route_addr_hi, route_addr_lo};
  // Two equal samples in a row are needed, which filters skew between the bits.
  wire stable = tick && (addrSync_ff == addrSample_ff);
  // A full FIFO refuses the push; the address is offered again at the next tick.
  wire pushRoute = stable && (addrSync_ff != route_ff) && fifoReady;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addrMeta_ff <= ROUTE_RESET;
      addrSync_ff <= ROUTE_RESET;
    end else begin
      addrMeta_ff <= rawAddr;
      addrSync_ff <= addrMeta_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_ff <= '0;
      addrSample_ff <= ROUTE_RESET;
    end else begin
      tickCnt_ff <= tick ? '0 : tickCnt_ff + 16'h0001;
      if (tick) addrSample_ff <= addrSync_ff;
    end
  end

  // Route updates pass a FIFO; it drains at once, so latency stays within 2.6 us.
  route_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(pushRoute),
    .inReady(fifoReady),
    .inData(addrSync_ff),
    .outValid(fifoValid),
    .outReady(1'b1),
    .outData(fifoData)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      route_ff <= ROUTE_RESET;
    end else if (fifoValid) begin
      route_ff <= fifoData;
    end
  end

  assign routeChange = fifoValid && (fifoData != route_ff);

  // The select level passes straight through, only the enable is decoded.
  wire [3:0] enableOneHot = 4'h1 << route_ff;
  assign routed_select_0 = host_select_n;
  assign routed_select_1 = host_select_n;
  assign routed_select_2 = host_select_n;
  assign routed_select_3 = host_select_n;
  assign routed_select_0_oe_n = ~enableOneHot[0];
  assign routed_select_1_oe_n = ~enableOneHot[1];
  assign routed_select_2_oe_n = ~enableOneHot[2];
  assign routed_select_3_oe_n = ~enableOneHot[3];
endmodule
